//--- hdl/fhl_pkg.sv
// package for the fault history log: object map, entry layout, timing
// =====================================================================
// Function
// RQ1: keep the latest sixteen faults with timestamps, held across power loss; here reset empties the log.
// RQ2: newest fault sits at first position, oldest at last position.
// RQ3: when full, drop oldest, shift all down, insert new fault first.
// RQ4: master reaches log via SDO to object 1003h; device serves it.
// RQ5: reading sub-index 00h returns depth, always sixteen.
// RQ6: sub-indexes 01h..10h return entries, newest lowest, oldest highest.
// RQ7: each entry is a 32-bit fault plus timestamp word.
// RQ8: first byte fault code, next byte generic fault indication as in emergencies.
// RQ9: an empty position reads back as zero.
// RQ10: timestamp is current free-running 16-bit hour counter value.
// RQ11: writing zero to sub-index 00h erases all entries.
// RQ12: after clear, all bytes of sub-indexes 01h..10h read zero; a fault in the same cycle as the clear still lands at sub-index 01h.
// RQ13: 16-bit hour stamp fills the two bytes after code and generic bytes.
package fhl_pkg;
    localparam logic [15:0] FHL_OBJ_INDEX = 16'h1003;
    localparam logic [7:0] FHL_SUB_DEPTH = 8'h00;
    localparam logic [7:0] FHL_SUB_FIRST = 8'h01;
    localparam logic [7:0] FHL_SUB_LAST = 8'h10;
    localparam logic [7:0] FHL_DEPTH_VALUE = 8'h10;
    localparam logic [7:0] FHL_CLEAR_VALUE = 8'h00;
    localparam logic [31:0] FHL_EMPTY_ENTRY = 32'h0000_0000;
    // generic fault indication byte, shared with the emergency message
    localparam logic [7:0] FHL_GENERIC_FAULT = 8'h01;
    localparam int FHL_CLK_HZ = 100_000_000;
    localparam int FHL_HOUR_S = 3600;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] generic;
        logic [15:0] hours;
    } fhl_entry_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] data;
    } fhl_sdo_req_s;

    typedef struct packed {
        logic valid;
        logic abort;
        logic [31:0] data;
    } fhl_sdo_rsp_s;
endpackage

//--- hdl/fhl_fault_history_log.sv
// fault history log core: sixteen-deep shifting log served over sdo
`timescale 1ns/1ps
`default_nettype none
module fhl_fault_history_log #(
    parameter int DEPTH = 16,
    parameter longint HOUR_CYCLES = 64'(fhl_pkg::FHL_CLK_HZ) * fhl_pkg::FHL_HOUR_S
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic fault_valid_in,
    input wire logic [7:0] fault_code_in,
    input wire fhl_pkg::fhl_sdo_req_s sdo_req_in,
    output fhl_pkg::fhl_sdo_rsp_s sdo_rsp_out,
    output logic [15:0] hour_count_out,
    output logic clear_done_out
);
    import fhl_pkg::*;

    // the object map fixes sixteen entries; any other depth cannot be served
    if (DEPTH != 16 || HOUR_CYCLES < 1) begin : g_bad_params
        $error("fhl: unsupported parameters");
    end

    // =================================================================
    // hour counter
    // =================================================================
    logic [63:0] tick;
    logic [63:0] next_tick;
    logic [15:0] hours;
    logic [15:0] next_hours;

    always_comb begin
        next_tick = tick + 64'h1;
        next_hours = hours;
        if (next_tick >= 64'(HOUR_CYCLES)) begin
            next_tick = '0;
            next_hours = hours + 16'h0001; // see RQ10
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick <= '0;
            hours <= '0;
        end else begin
            tick <= next_tick;
            hours <= next_hours;
        end
    end

    // =================================================================
    // log storage
    // =================================================================
    // retention across power loss is the storage macro's job; this array
    // models it and is wiped only by reset or an explicit clear
    fhl_entry_s log_mem [DEPTH]; // see RQ1
    fhl_entry_s next_log_mem [DEPTH];
    logic is_clear;
    logic next_is_clear;

    function automatic logic sdo_hits(input fhl_sdo_req_s r, input logic [7:0] s);
        sdo_hits = r.valid && r.index == FHL_OBJ_INDEX && r.sub == s;
    endfunction

    always_comb begin
        next_is_clear = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            next_log_mem[i] = log_mem[i];
        end
        if (sdo_hits(sdo_req_in, FHL_SUB_DEPTH) && sdo_req_in.write
            && sdo_req_in.data[7:0] == FHL_CLEAR_VALUE) begin
            // clear first, then a fault in the same cycle still lands
            for (int i = 0; i < DEPTH; i++) begin
                next_log_mem[i] = FHL_EMPTY_ENTRY; // see RQ11 RQ12 RQ9
            end
            next_is_clear = 1'b1;
        end
        if (fault_valid_in) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                next_log_mem[i] = next_log_mem[i - 1]; // see RQ3
            end
            next_log_mem[0].code = fault_code_in; // see RQ2 RQ8
            next_log_mem[0].generic = FHL_GENERIC_FAULT; // see RQ8
            next_log_mem[0].hours = hours; // see RQ10 RQ13
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                log_mem[i] <= FHL_EMPTY_ENTRY;
            end
            is_clear <= 1'b0;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                log_mem[i] <= next_log_mem[i];
            end
            is_clear <= next_is_clear;
        end
    end

    // =================================================================
    // sdo answer
    // =================================================================
    fhl_sdo_rsp_s rsp;
    fhl_sdo_rsp_s next_rsp;
    logic [7:0] slot;

    always_comb begin
        slot = sdo_req_in.sub - FHL_SUB_FIRST;
        next_rsp = '0;
        if (sdo_req_in.valid) begin
            next_rsp.valid = 1'b1;
            if (sdo_req_in.index != FHL_OBJ_INDEX) begin
                next_rsp.abort = 1'b1; // see RQ4
            end else if (sdo_req_in.sub == FHL_SUB_DEPTH) begin
                if (sdo_req_in.write) begin
                    next_rsp.abort = sdo_req_in.data[7:0] != FHL_CLEAR_VALUE;
                end else begin
                    next_rsp.data = 32'(FHL_DEPTH_VALUE); // see RQ5
                end
            end else if (sdo_req_in.sub >= FHL_SUB_FIRST && sdo_req_in.sub <= FHL_SUB_LAST
                         && !sdo_req_in.write) begin
                next_rsp.data = log_mem[slot[3:0]]; // see RQ6 RQ7
            end else begin
                next_rsp.abort = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

    assign sdo_rsp_out = rsp;
    assign hour_count_out = hours;
    assign clear_done_out = is_clear;
endmodule
`default_nettype wire

//--- sim/fhl_chk.sv
// checker: sdo answer timing, refusals and log clear
`timescale 1ns/1ps
`default_nettype none
module fhl_chk (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire fhl_pkg::fhl_sdo_req_s sdo_req_in,
    input wire fhl_pkg::fhl_sdo_rsp_s sdo_rsp_out,
    input wire logic clear_done_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    wire fhl_pkg::fhl_sdo_req_s q = sdo_req_in;
    wire fhl_pkg::fhl_sdo_rsp_s a = sdo_rsp_out;
    wire logic clr = q == {2'h3, 16'h1003, 8'h00, 32'h0};
    property p_rsp; q.valid |=> a.valid; endproperty
    a_rsp: assert property (p_rsp) else $error("no answer");
    property p_idle; !q.valid |=> !a.valid; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_idx; q.valid && q.index != 16'h1003 |=> a.abort; endproperty
    a_idx: assert property (p_idx) else $error("foreign index served");
    // depth read: valid, read, index 1003h, sub 00h
    property p_len; q[57:32] == 26'h2100300 |=> !a.abort && a.data[7:0] == 8'h10; endproperty
    a_len: assert property (p_len) else $error("bad depth");
    property p_ro; q.valid && q.write && q.sub != 8'h00 |=> a.abort; endproperty
    a_ro: assert property (p_ro) else $error("entry write taken");
    property p_rng; q.valid && q.sub > 8'h10 |=> a.abort; endproperty
    a_rng: assert property (p_rng) else $error("sub out of range taken");
    property p_clr; clr |=> clear_done_out && !a.abort; endproperty
    a_clr: assert property (p_clr) else $error("clear not done");
    property p_cd; clear_done_out |-> $past(clr); endproperty
    a_cd: assert property (p_cd) else $error("stray clear");
    c_len: cover property (q[57:32] == 26'h2100300);
    c_clr: cover property (clr);
    c_bad: cover property (q.valid && a.abort);
endmodule
`default_nettype wire

//--- sim/fhl_sdo_master.sv
// sdo master model: one-cycle request, answer taken one cycle later
`timescale 1ns/1ps
`default_nettype none
module fhl_sdo_master (
    input wire logic clk_sys_in,
    input wire fhl_pkg::fhl_sdo_rsp_s sdo_rsp_in,
    output var fhl_pkg::fhl_sdo_req_s sdo_req_out
);
    initial sdo_req_out = '0;
    task automatic xfer(input fhl_pkg::fhl_sdo_req_s q, output fhl_pkg::fhl_sdo_rsp_s r);
        @(negedge clk_sys_in);
        sdo_req_out <= q;
        @(negedge clk_sys_in);
        // released lines show the inverse, never a stale copy
        sdo_req_out <= {1'h0, ~q[56:0]};
        r = sdo_rsp_in;
    endtask
endmodule
`default_nettype wire

//--- sim/tb_fault_history_log.sv
// testbench for the fault history log
`timescale 1ns/1ps
`default_nettype none
module tb_fault_history_log;
    logic clk_sys_in = 1'h0, reset_n_in = 1'h0, fault_valid_in = 1'h0;
    logic [7:0] fault_code_in = 8'h00;
    fhl_pkg::fhl_sdo_req_s sdo_req_in;
    fhl_pkg::fhl_sdo_rsp_s sdo_rsp_out;
    logic [15:0] hour_count_out;
    int miscompares = 0, tests_run = 0;
    fhl_fault_history_log #(.HOUR_CYCLES(1000)) u_dut (.clk_sys_in, .reset_n_in, .fault_valid_in,
        .fault_code_in, .sdo_req_in, .sdo_rsp_out, .hour_count_out, .clear_done_out());
    fhl_sdo_master u_mst (.clk_sys_in, .sdo_rsp_in(sdo_rsp_out), .sdo_req_out(sdo_req_in));
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        miscompares += int'(seen !== exp);
        if (seen !== exp) $display("ERROR %0t got %h exp %h", $time, seen, exp);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // m low: abort answers carry no defined data, so only valid and abort count
    task automatic sdo(input logic [7:0] sb, input logic [33:0] exp, input logic w = 1'h0,
            input logic [31:0] d = 32'h0, input logic m = 1'h1, input logic [15:0] ix = 16'h1003);
        fhl_pkg::fhl_sdo_rsp_s r;
        u_mst.xfer({1'h1, w, ix, sb, d}, r);
        chk(m ? r : {r[33:32], 32'h0}, exp);
        if (r.valid !== 1'h1) print_verdict();
    endtask
    initial forever #5 clk_sys_in = ~clk_sys_in;
    initial begin
        repeat (12) @(negedge clk_sys_in);
        reset_n_in = 1'h1;
        sdo(8'h00, {2'h2, 32'h10});
        repeat (1200) @(negedge clk_sys_in);
        for (int i = 1; i <= 17; i++) begin
            @(negedge clk_sys_in);
            fault_valid_in = 1'h1;
            fault_code_in = 8'(i);
        end
        @(negedge clk_sys_in);
        fault_valid_in = 1'h0;
        chk({18'h0, hour_count_out}, 34'h1);
        sdo(8'h01, {2'h3, 32'h0}, 1'h1, 32'h0, 1'h0);
        sdo(8'h11, {2'h3, 32'h0}, 1'h0, 32'h0, 1'h0);
        sdo(8'h01, {2'h3, 32'h0}, 1'h0, 32'h0, 1'h0, 16'h1004);
        for (int i = 1; i <= 16; i++) sdo(8'(i), {2'h2, 8'(18 - i), 24'h010001});
        $display("fill and refusal tests done");
        sdo(8'h00, {2'h2, 32'h0}, 1'h1, 32'h0, 1'h0);
        for (int i = 1; i <= 16; i++) sdo(8'(i), {2'h2, 32'h0});
        $display("clear test done");
        print_verdict();
    end
endmodule
bind fhl_fault_history_log fhl_chk u_chk (.clk_sys_in, .reset_n_in, .sdo_req_in,
    .sdo_rsp_out, .clear_done_out);
`default_nettype wire
